// ### design/burst2_pkg.sv
// Constants shared by both ends of the two-beat double-rate memory port.
// Assumes a single 10 MHz system clock; link clocks are sampled as data.
//
// Notes on behaviour
// R1: Operations start at main clock rising edge.
// R2: Read address, selects, first beat on rising.
// R3: Write address, second beat on inverted rising.
// R4: Controller shares address bus at double rate; this controller drives one command's address for the whole main cycle.
// R5: Exactly two beats per read or write.
// R6: Controller gives first beat with write command.
// R7: Write data buffered ahead of its address.
// R8: Byte masks sampled with each data beat.
// R9: First read beat 1.5 cycles after command.
// R10: Second read beat on third output rising.
// R11: Output clocks both high select main clock.
// R12: Returned strobes toggle aligned with read beats.
// R13: Independent read and write ports, concurrent commands.
// R14: Organisation 2Mx36 or 4Mx18 sets widths.
// R15: Low select starts operation, high stays idle.
// R16: Reads see buffered write data, byte merged.
package burst2_pkg;
	// ==========================================================
	// Organisation
	localparam int DATA_W       = 36;  // see R14
	localparam int LANES        = 4;
	localparam int ADDR_W       = 21;
	localparam int MEM_ADDR_W   = 6;   // Modelled array depth, flip-flop storage
	localparam int BEATS        = 2;   // see R5
	// ==========================================================
	// Link timing
	localparam int CLK_NS       = 100;
	localparam int LINK_NS      = 800;
	localparam int LINK_HALF    = (LINK_NS / CLK_NS) / 2;
	localparam int FIFO_DEPTH   = 32;
endpackage

// ### design/burst2_if.sv
// Pin bundle between the memory device and its controller.
// Assumes both ends run on the same system clock but see pins as async.
`timescale 1ns/1ps
interface burst2_if;
	logic                            main_clk;
	logic                            main_clk_n;
	logic                            out_clk;
	logic                            out_clk_n;
	logic [burst2_pkg::ADDR_W-1:0]   address_bus;
	logic                            read_select_n;
	logic                            write_select_n;
	logic [burst2_pkg::LANES-1:0]    byte_write_mask_n;
	logic [burst2_pkg::DATA_W-1:0]   data_in;
	logic [burst2_pkg::DATA_W-1:0]   data_out;
	logic                            returned_strobe;
	logic                            inverted_returned_strobe;

	modport device (
		input  main_clk, main_clk_n, out_clk, out_clk_n, address_bus,
		input  read_select_n, write_select_n, byte_write_mask_n, data_in,
		output data_out, returned_strobe, inverted_returned_strobe
	);
	modport controller (
		output main_clk, main_clk_n, out_clk, out_clk_n, address_bus,
		output read_select_n, write_select_n, byte_write_mask_n, data_in,
		input  data_out, returned_strobe, inverted_returned_strobe
	);
endinterface

// ### design/burst2_fifo.sv
// Parameterised valid/ready FIFO in flip-flops.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module burst2_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_nrst,
	// Fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Drain side
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0]   count;
	} state_t;
	state_t s;
	state_t next_s;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	// ==========================================================
	// Pointer control; full and empty come from the count
	always_comb begin
		push   = i_in_valid && o_in_ready;
		pop    = o_out_valid && i_out_ready;
		next_s = s;
		if (push) begin
			next_s.wr = s.wr + AW'(1);
		end
		if (pop) begin
			next_s.rd = s.rd + AW'(1);
		end
		next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Storage has no reset; only valid entries are ever read
	always_ff @(posedge i_clock) begin
		if (push) begin
			mem[s.wr] <= i_in_data;
		end
	end

	assign o_in_ready  = s.count != (AW+1)'(DEPTH);
	assign o_out_valid = s.count != '0;
	assign o_out_data  = mem[s.rd];
endmodule

// ### design/burst2_device.sv
// Memory device end: samples link clocks, writes and reads the array.
// Assumes the controller keeps pin timing; link clocks are sampled.
`timescale 1ns/1ps
module burst2_device (
	// Clock and reset
	input  wire logic  i_clock,
	input  wire logic  i_nrst,
	// Link pins
	burst2_if.device   link,
	// Status
	output logic       o_read_seen,
	output logic       o_write_seen
);
	localparam int DW = burst2_pkg::DATA_W;
	localparam int LN = burst2_pkg::LANES;
	localparam int LW = DW / LN;
	localparam int MA = burst2_pkg::MEM_ADDR_W;
	localparam int AW = burst2_pkg::ADDR_W;
	localparam int PW = AW + 2 + LN + DW;

	typedef struct packed {
		logic [1:0]    k1, k2, kn1, kn2, c1, c2, cn1, cn2;
		logic          k_q, kn_q, c_q, cn_q;
		logic [AW-1:0] rd_addr;
		logic          rd_pend, wr_pend;
		logic [DW-1:0] wd0, wd1;
		logic [LN-1:0] wm0, wm1;
		logic [AW-1:0] wa;
		logic          buf_valid;
		logic [DW-1:0] rq0, rq1;
		logic          ph_a;      // Fetched read waiting for its first beat edge
		logic          ph_b;      // Second beat owed on the next output rise
		logic [DW-1:0] hold;      // Second beat kept apart from the next fetch
		logic [PW-1:0] p1, p2, p3;  // Pin samples, p3 lines up with the edge's last low
		logic [DW-1:0] dout;
		logic          cq;
		logic          rseen, wseen;
	} state_t;
	state_t s;
	state_t next_s;
	logic [DW-1:0] mem [2**MA];
	logic          k_rise, kn_rise, c_rise, cn_rise, use_k, o_rise, on_rise;
	logic          commit;
	logic [AW-1:0] pin_addr;
	logic          pin_rsel_n;
	logic          pin_wsel_n;
	logic [LN-1:0] pin_mask_n;
	logic [DW-1:0] pin_data;

	// Pins are taken from the sample just before the detected edge, so the
	// controller may change them at the edge itself and still meet setup
	assign {pin_addr, pin_rsel_n, pin_wsel_n, pin_mask_n, pin_data} = s.p3;

	// ==========================================================
	// Merge per lane of a buffered beat over array data
	function automatic logic [DW-1:0] merge(input logic [DW-1:0] base,
		input logic [DW-1:0] nd, input logic [LN-1:0] mask_n);
		logic [DW-1:0] r;
		r = base;
		for (int i = 0; i < LN; i++) begin
			if (!mask_n[i]) begin
				r[i*LW +: LW] = nd[i*LW +: LW];  // see R8
			end
		end
		return r;
	endfunction

	// ==========================================================
	// Edge finding and command capture
	always_comb begin
		next_s    = s;
		next_s.k1 = {s.k1[0], link.main_clk};
		next_s.k2 = {s.k2[0], link.main_clk_n};
		next_s.c1 = {s.c1[0], link.out_clk};
		next_s.c2 = {s.c2[0], link.out_clk_n};
		next_s.k_q  = s.k1[1];
		next_s.kn_q = s.k2[1];
		next_s.c_q  = s.c1[1];
		next_s.cn_q = s.c2[1];
		next_s.p1   = {link.address_bus, link.read_select_n, link.write_select_n,
			link.byte_write_mask_n, link.data_in};
		next_s.p2   = s.p1;
		next_s.p3   = s.p2;
		k_rise  = s.k1[1] && !s.k_q;   // see R1
		kn_rise = s.k2[1] && !s.kn_q;
		c_rise  = s.c1[1] && !s.c_q;
		cn_rise = s.c2[1] && !s.cn_q;
		use_k   = s.c1[1] && s.c2[1];  // see R11
		o_rise  = use_k ? k_rise : c_rise;
		on_rise = use_k ? kn_rise : cn_rise;
		commit  = 1'b0;
		// Rising main edge: read address, selects, first beat
		if (k_rise) begin
			next_s.rd_pend = !pin_rsel_n;            // see R15
			next_s.wr_pend = !pin_wsel_n;            // see R15
			next_s.rd_addr = pin_addr;               // see R2
			if (!pin_wsel_n) begin
				next_s.wd0 = pin_data;               // see R7
				next_s.wm0 = pin_mask_n;
			end
			if (!pin_rsel_n) begin
				next_s.rseen = 1'b1;
			end
		end
		// Inverted main edge: write address and second beat
		if (kn_rise && s.wr_pend) begin
			next_s.wa        = pin_addr;             // see R3
			next_s.wd1       = pin_data;
			next_s.wm1       = pin_mask_n;
			next_s.buf_valid = 1'b1;
			next_s.wr_pend   = 1'b0;
			next_s.wseen     = 1'b1;
		end
		// Output: beat 0 on the second inverted rise, beat 1 on the next rise;
		// two flags let back-to-back reads overlap without losing one
		if (on_rise && s.ph_a) begin
			next_s.dout = s.rq0;                     // see R9
			next_s.hold = s.rq1;
			next_s.cq   = 1'b0;                      // see R12
			next_s.ph_a = 1'b0;
			next_s.ph_b = 1'b1;
		end
		if (o_rise && s.ph_b) begin
			next_s.dout = s.hold;                    // see R10
			next_s.cq   = 1'b1;                      // see R12
			next_s.ph_b = 1'b0;                      // see R5
		end
		// Read fetch once the address is held, buffer data bypasses
		if (kn_rise && s.rd_pend) begin
			next_s.ph_a = 1'b1;                      // see R9
			next_s.rq0 = mem[s.rd_addr[MA-1:0]];
			next_s.rq1 = mem[s.rd_addr[MA-1:0] + MA'(1)];
			if (s.buf_valid && s.wa == s.rd_addr) begin
				next_s.rq0 = merge(mem[s.rd_addr[MA-1:0]], s.wd0, s.wm0);  // see R16
				next_s.rq1 = merge(mem[s.rd_addr[MA-1:0] + MA'(1)], s.wd1, s.wm1);
			end
			next_s.rd_pend = 1'b0;
		end
		// Buffered write retires on the next main edge
		if (k_rise && s.buf_valid) begin
			commit           = 1'b1;
			next_s.buf_valid = 1'b0;
		end
		next_s.cn1 = '0;
		next_s.cn2 = '0;
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			s    <= '0;
			s.cq <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Array write of both beats, independent of the read port
	always_ff @(posedge i_clock) begin
		if (commit) begin
			mem[s.wa[MA-1:0]]          <= merge(mem[s.wa[MA-1:0]], s.wd0, s.wm0);  // see R13
			mem[s.wa[MA-1:0] + MA'(1)] <= merge(mem[s.wa[MA-1:0] + MA'(1)], s.wd1, s.wm1);
		end
	end

	assign link.data_out                 = s.dout;
	assign link.returned_strobe          = s.cq;
	assign link.inverted_returned_strobe = !s.cq;
	assign o_read_seen                   = s.rseen;
	assign o_write_seen                  = s.wseen;
endmodule

// ### design/burst2_controller.sv
// Controller end: divides its clock into the main clock pair, queues user
// commands in a FIFO and issues them on the double-rate pins.
// Assumes the device answers with strobes aligned to the read beats.
`timescale 1ns/1ps
module burst2_controller (
	// Clock and reset
	input  wire logic                           i_clock,
	input  wire logic                           i_nrst,
	// Command stream {is_write, addr, beat0, beat1, mask0, mask1}
	input  wire logic                           i_cmd_valid,
	input  wire logic [1+burst2_pkg::ADDR_W+2*burst2_pkg::DATA_W+2*burst2_pkg::LANES-1:0] i_cmd,
	output logic                                o_cmd_ready,
	// Read data
	output logic                                o_rd_valid,
	output logic [burst2_pkg::DATA_W-1:0]       o_rd_data,
	// Link pins
	burst2_if.controller                        link
);
	localparam int DW = burst2_pkg::DATA_W;
	localparam int LN = burst2_pkg::LANES;
	localparam int AW = burst2_pkg::ADDR_W;
	localparam int CW = 1 + AW + 2*DW + 2*LN;

	typedef struct packed {
		logic [7:0]    div;
		logic          k;
		logic [CW-1:0] cur;
		logic          active;
		logic [1:0]    s1;
		logic          sq;
		logic          rv;
		logic [DW-1:0] rd;
	} state_t;
	state_t s;
	state_t next_s;
	logic          f_valid;
	logic [CW-1:0] f_data;
	logic          f_ready;
	logic          half;

	burst2_fifo #(.WIDTH(CW), .DEPTH(burst2_pkg::FIFO_DEPTH)) u_fifo (
		.i_clock    (i_clock),
		.i_nrst     (i_nrst),
		.i_in_valid (i_cmd_valid),
		.i_in_data  (i_cmd),
		.o_in_ready (o_cmd_ready),
		.o_out_valid(f_valid),
		.o_out_data (f_data),
		.i_out_ready(f_ready)
	);

	// ==========================================================
	// Clock divider and command sequencing
	always_comb begin
		next_s     = s;
		half       = s.div == 8'(burst2_pkg::LINK_HALF - 1);
		f_ready    = half && s.k;    // Take command at main fall, held through high phase
		next_s.div = half ? 8'h00 : s.div + 8'h01;
		next_s.rv  = 1'b0;
		if (half) begin
			next_s.k = !s.k;
			if (s.k) begin
				next_s.active = f_valid;             // see R1
				next_s.cur    = f_data;
			end
		end
		// Strobe edges mark each returned beat
		next_s.s1 = {s.s1[0], link.returned_strobe};
		next_s.sq = s.s1[1];
		if (s.s1[1] != s.sq) begin
			next_s.rv = 1'b1;                          // see R12
			next_s.rd = link.data_out;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			s    <= '0;
			s.sq <= 1'b1;
			s.s1 <= 2'h3;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Pins: main phase carries read address and beat 0
	logic          is_wr;
	logic [AW-1:0] addr;
	assign is_wr = s.cur[CW-1];
	assign addr  = s.cur[CW-2 -: AW];
	assign link.main_clk       = s.k;
	assign link.main_clk_n     = !s.k;
	assign link.out_clk        = 1'b1;               // see R11
	assign link.out_clk_n      = 1'b1;
	assign link.address_bus    = addr;               // see R4
	assign link.read_select_n  = !(s.active && !is_wr && s.k == 1'b0);  // see R15
	assign link.write_select_n = !(s.active && is_wr && s.k == 1'b0);   // see R15
	assign link.data_in        = s.k ? s.cur[2*LN +: DW] : s.cur[2*LN+DW +: DW];  // see R6
	assign link.byte_write_mask_n = s.k ? s.cur[0 +: LN] : s.cur[LN +: LN];    // see R8
	assign o_rd_valid = s.rv;
	assign o_rd_data  = s.rd;
endmodule

// ### sim/burst2_monitor.sv
// Checker of the pin bundle between the device and controller ends.
// Assumes it sits beside the interface and samples the clock, select, strobe and read data pins on i_clock.
`timescale 1ns/1ps
module burst2_monitor (
	// Clock and reset
	input  wire logic                          i_clock,
	input  wire logic                          i_nrst,
	// Link pins
	input  wire logic                          main_clk,
	input  wire logic                          main_clk_n,
	input  wire logic                          out_clk,
	input  wire logic                          out_clk_n,
	input  wire logic                          read_select_n,
	input  wire logic                          write_select_n,
	input  wire logic [burst2_pkg::DATA_W-1:0] data_out,
	input  wire logic                          returned_strobe,
	input  wire logic                          inverted_returned_strobe
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	// ==========================================================
	// Helper logic
	logic       main_q;
	logic       strobe_q;
	logic       rsel_q;
	logic [3:0] pend;
	// Beats still owed by the device; an edge with none owed is an extra beat
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			main_q   <= 1'b0;
			strobe_q <= 1'b1;
			rsel_q   <= 1'b1;
			pend     <= 4'h0;
		end else begin
			main_q   <= main_clk;
			strobe_q <= returned_strobe;
			rsel_q   <= read_select_n;
			pend     <= pend + ((main_clk && !main_q && !rsel_q) ? 4'h2 : 4'h0)
				- ((returned_strobe != strobe_q) ? 4'h1 : 4'h0);
		end
	end
	// ==========================================================
	// Properties
	sequence s_read_cmd;
		$rose(main_clk) && !rsel_q;
	endsequence
	sequence s_beat;
		$changed(returned_strobe);
	endsequence
	property p_read_two_beats;
		s_read_cmd |-> ##[1:40] s_beat ##[1:12] s_beat;
	endproperty
	property p_no_extra_beat;
		(returned_strobe != strobe_q) |-> pend != 4'h0;
	endproperty
	property p_strobe_pair;
		returned_strobe != inverted_returned_strobe;
	endproperty
	property p_data_with_strobe;
		$changed(data_out) |-> s_beat;
	endproperty
	property p_out_tied;
		out_clk && out_clk_n;
	endproperty
	property p_main_pair;
		main_clk_n == !main_clk;
	endproperty
	property p_main_period;
		$rose(main_clk) |-> main_clk [*4] ##1 !main_clk;
	endproperty
	property p_rsel_setup;
		$fell(read_select_n) |-> !main_clk;
	endproperty
	property p_wsel_setup;
		$fell(write_select_n) |-> !main_clk;
	endproperty
	a_read_two_beats: assert property (p_read_two_beats)
		else $error("read without two beats");
	a_no_extra_beat: assert property (p_no_extra_beat)
		else $error("strobe edge without a pending read beat");
	a_strobe_pair: assert property (p_strobe_pair)
		else $error("returned strobes not complementary");
	a_data_with_strobe: assert property (p_data_with_strobe)
		else $error("read data moved without a strobe edge");
	a_out_tied: assert property (p_out_tied)
		else $error("output clocks not held high");
	a_main_pair: assert property (p_main_pair)
		else $error("main clock pair not complementary");
	a_main_period: assert property (p_main_period)
		else $error("main clock high phase has wrong length");
	a_rsel_setup: assert property (p_rsel_setup)
		else $error("read select fell while main clock high");
	a_wsel_setup: assert property (p_wsel_setup)
		else $error("write select fell while main clock high");
endmodule

// ### sim/burst2_ddr_sram_port_test.sv
// Self-checking bench: controller and device joined by the pin interface.
// Assumes a reference array in the bench predicts every read beat.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module burst2_ddr_sram_port_test;
	localparam int DW = burst2_pkg::DATA_W;
	localparam int LW = DW / burst2_pkg::LANES;
	localparam int CW = 1 + burst2_pkg::ADDR_W + 2 * DW + 2 * burst2_pkg::LANES;
	logic          i_clock   = 1'b0;
	logic          i_nrst    = 1'b0;
	logic          cmd_valid = 1'b0;
	logic [CW-1:0] cmd       = '0;
	logic          full_seen = 1'b0;
	logic          cmd_ready, rd_valid, read_seen, write_seen;
	logic [DW-1:0] rd_data;
	logic [DW-1:0] mem [64];
	logic [DW-1:0] exp_q [$];
	logic [5:0]    last = 6'h00;
	int            err_count = 0;
	int            check_count = 0;
	int            seed = 64;
	burst2_if link ();
	// ==========================================================
	// Both ends and the checker
	burst2_controller burst2_controller_i (.i_clock(i_clock), .i_nrst(i_nrst),
		.i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_cmd_ready(cmd_ready),
		.o_rd_valid(rd_valid), .o_rd_data(rd_data), .link(link));
	burst2_device burst2_device_i (.i_clock(i_clock), .i_nrst(i_nrst), .link(link),
		.o_read_seen(read_seen), .o_write_seen(write_seen));
	burst2_monitor burst2_monitor_i (.i_clock(i_clock), .i_nrst(i_nrst),
		.main_clk(link.main_clk), .main_clk_n(link.main_clk_n), .out_clk(link.out_clk),
		.out_clk_n(link.out_clk_n), .read_select_n(link.read_select_n),
		.write_select_n(link.write_select_n), .data_out(link.data_out),
		.returned_strobe(link.returned_strobe),
		.inverted_returned_strobe(link.inverted_returned_strobe));
	// 100 ns system clock
	always #50 i_clock = ~i_clock;
	// ==========================================================
	// Reference model and drivers
	task automatic wr_lanes(input logic [5:0] a, input logic [DW-1:0] d, input logic [3:0] m_n);
		for (int l = 0; l < burst2_pkg::LANES; l++) begin
			if (!m_n[l]) mem[a][LW*l +: LW] = d[LW*l +: LW];
		end
	endtask
	// Valid stays up between calls; a refusal holds the command unchanged
	task automatic push(input logic w, input logic [5:0] a, input logic [3:0] m0,
		input logic [3:0] m1);
		logic [DW-1:0] b0;
		logic [DW-1:0] b1;
		b0 = DW'({$random(seed), $random(seed)});
		b1 = DW'({$random(seed), $random(seed)});
		@(negedge i_clock);
		cmd_valid = 1'b1;
		cmd = {w, 15'h0000, a, b0, b1, m0, m1};
		while (cmd_ready !== 1'b1) begin
			full_seen = 1'b1;
			@(negedge i_clock);
		end
		@(posedge i_clock);
		if (w) begin
			wr_lanes(a, b0, m0);
			wr_lanes(a + 6'h01, b1, m1);
		end else begin
			exp_q.push_back(mem[a]);
			exp_q.push_back(mem[a + 6'h01]);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Beats come back in command order, one pulse each
	always @(negedge i_clock) begin
		if (rd_valid === 1'b1) begin
			`CHK(exp_q.size() > 0, 1'b1)
			if (exp_q.size() > 0) `CHK(rd_data, exp_q.pop_front())
		end
	end
	// About 1100 cycles of traffic expected; some 27 times that means a hang
	initial begin
		#3000000;
		err_count++;
		test_done();
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge i_clock);
		@(negedge i_clock);
		`CHK(link.read_select_n, 1'b1)
		`CHK(link.returned_strobe, 1'b1)
		i_nrst = 1'b1;
		// Fill the array first; the FIFO stays short of full until the mixed traffic
		for (int a = 0; a < 64; a += 2) push(1'b1, 6'(a), 4'h0, 4'h0);
		// Mixed traffic, every fourth command reuses the previous address
		for (int n = 0; n < 100; n++) begin
			if (n % 4 != 3) last = 6'($random(seed)) & 6'h3E;
			push(1'($random(seed)), last, 4'($random(seed)), 4'($random(seed)));
		end
		@(negedge i_clock);
		cmd_valid = 1'b0;
		for (int t = 0; t < 3000 && exp_q.size() > 0; t++) @(negedge i_clock);
		repeat (40) @(negedge i_clock);
		`CHK(exp_q.size(), 0)
		`CHK(full_seen, 1'b1)
		`CHK(read_seen, 1'b1)
		`CHK(write_seen, 1'b1)
		test_done();
	end
endmodule
